//--- design/mrs_supervisor.sv
// fault supervisor: stall retries, low-speed shutdown, over-temperature, zero-motion hold
`timescale 1ns/1ps
`default_nettype none
`include "mrs_consts.svh"
module mrs_supervisor #(
    parameter int unsigned TICK_CYC       = `MRS_TICK_CYC,
    parameter int unsigned ATTEMPT_MS     = `MRS_ATTEMPT_MS,
    parameter int unsigned STALL_PERIOD_MS = `MRS_STALL_PERIOD_MS,
    parameter int unsigned STALL_TRIES    = `MRS_STALL_TRIES,
    parameter int unsigned SLOW_PERIOD_MS = `MRS_SLOW_PERIOD_MS,
    parameter int unsigned DEV_LIMIT_MS   = `MRS_DEV_LIMIT_MS,
    parameter int unsigned LOWSPD_WAIT_MS = `MRS_LOWSPD_WAIT_MS,
    parameter int unsigned SPD_W          = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             run_req_pin,
    input  wire logic             blocked_in,
    input  wire logic             motor_hot_in,
    input  wire logic             elec_hot_in,
    input  wire logic [SPD_W-1:0] speed_set,
    input  wire logic [SPD_W-1:0] speed_act,
    output logic                  motor_drive,
    output logic                  hold_brake,
    output logic                  error_out,
    output var mrs_pkg::mrs_state_t state_out
);
    import mrs_pkg::*;

    // sequencer state, timers and the speed band arithmetic
    logic              run_s1_r;
    logic              run_s2_r;
    logic              tick_ms;
    mrs_state_t        state_r;
    logic [31:0]       tmr_r;
    logic [31:0]       dev_tmr_r;
    logic [7:0]        tries_r;
    logic              err_r;
    logic              hot;
    logic              speed_ok;
    logic [SPD_W+6:0]  diff_x100;
    logic [SPD_W+6:0]  lim_x100;

    // run request comes from a pin: two-flop synchroniser before any use
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            run_s1_r <= 1'b0;
            run_s2_r <= 1'b0;
        end else begin
            run_s1_r <= run_req_pin;
            run_s2_r <= run_s1_r;
        end
    end

    // shared ms time base; every timer below advances only on its pulse
    mrs_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick_ms (tick_ms)
    );

    // speed within the band: |act - set| * 100 <= set * 20
    // scaling both sides instead of dividing keeps the compare exact and cheap
    always_comb begin
        if (speed_act >= speed_set) begin
            diff_x100 = (SPD_W+7)'(speed_act - speed_set) * (SPD_W+7)'(100);
        end else begin
            diff_x100 = (SPD_W+7)'(speed_set - speed_act) * (SPD_W+7)'(100);
        end
        lim_x100 = (SPD_W+7)'(speed_set) * (SPD_W+7)'(`MRS_DEV_PCT);
    end
    assign speed_ok = (diff_x100 <= lim_x100);
    assign hot      = motor_hot_in | elec_hot_in;

    // deviation timer counts whole ms out of band while driving
    // limitation: the spin-up cycle after entering run may already count one tick
    // the limit is compared in whole ticks, so it trips on the tick that reaches the bound
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dev_tmr_r <= 32'h0;
        end else if (state_r != MRS_RUN || speed_ok || !run_s2_r) begin
            dev_tmr_r <= 32'h0;
        end else if (tick_ms) begin
            dev_tmr_r <= dev_tmr_r + 32'h1;
        end
    end

    // main sequencer; over-temperature takes precedence over everything
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= MRS_HOLD;
            tmr_r   <= 32'h0;
            tries_r <= 8'h0;
            err_r   <= 1'b0;
        end else if (hot) begin
            // hot wins even mid-retry, so the motor never drives while overheated
            state_r <= MRS_HOT;
            err_r   <= 1'b1;
            tmr_r   <= 32'h0;
        end else begin
            case (state_r)
                // idle: counters stay clear so a fresh request starts a new sequence
                MRS_HOLD: begin
                    tmr_r   <= 32'h0;
                    tries_r <= 8'h0;
                    err_r   <= 1'b0;
                    if (run_s2_r) begin
                        state_r <= MRS_RUN;
                    end
                end
                MRS_HOT: begin
                    // cooled: error clears alone, run resumes if still requested
                    err_r   <= 1'b0;
                    tries_r <= 8'h0;
                    state_r <= run_s2_r ? MRS_RUN : MRS_HOLD;
                end
                // a jam also reads as slow, so blockage is checked before the timer
                MRS_RUN: begin
                    if (!run_s2_r) begin
                        state_r <= MRS_HOLD;
                    end else if (blocked_in) begin
                        state_r <= MRS_STALL_WAIT;
                        tmr_r   <= 32'h0;
                    end else if (dev_tmr_r >= 32'(DEV_LIMIT_MS)) begin
                        state_r <= MRS_LOW_WAIT;
                        err_r   <= 1'b1;
                        tmr_r   <= 32'h0;
                    end else if (speed_ok) begin
                        // back in band: fault over, a new jam restarts the count
                        err_r   <= 1'b0;
                        tries_r <= 8'h0;
                    end
                end
                MRS_STALL_WAIT: begin
                    // off phase of the retry cycle, period minus attempt
                    // after the tenth try the long period applies until the jam clears
                    if (!run_s2_r) begin
                        state_r <= MRS_HOLD;
                    end else if (tick_ms) begin
                        if (tmr_r >= 32'((tries_r >= 8'(STALL_TRIES) ? SLOW_PERIOD_MS
                                          : STALL_PERIOD_MS) - ATTEMPT_MS - 1)) begin
                            state_r <= MRS_STALL_TRY;
                            tmr_r   <= 32'h0;
                        end else begin
                            tmr_r <= tmr_r + 32'h1;
                        end
                    end
                end
                // on phase: drive the motor; proper speed without a jam ends the fault
                MRS_STALL_TRY: begin
                    if (!run_s2_r) begin
                        state_r <= MRS_HOLD;
                    end else if (!blocked_in && speed_ok) begin
                        state_r <= MRS_RUN;
                        err_r   <= 1'b0;
                        tries_r <= 8'h0;
                    end else if (tick_ms) begin
                        if (tmr_r >= 32'(ATTEMPT_MS - 1)) begin
                            state_r <= MRS_STALL_WAIT;
                            tmr_r   <= 32'h0;
                            // the count saturates so the long period holds until cleared
                            if (tries_r < 8'(STALL_TRIES)) begin
                                tries_r <= tries_r + 8'h1;
                            end
                            if (tries_r >= 8'(STALL_TRIES - 1)) begin
                                err_r <= 1'b1;
                            end
                        end else begin
                            tmr_r <= tmr_r + 32'h1;
                        end
                    end
                end
                // motor off for the whole wait; the error stays until speed is proper
                MRS_LOW_WAIT: begin
                    if (!run_s2_r) begin
                        state_r <= MRS_HOLD;
                    end else if (tick_ms) begin
                        if (tmr_r >= 32'(LOWSPD_WAIT_MS - 1)) begin
                            state_r <= MRS_RUN;
                            tmr_r   <= 32'h0;
                        end else begin
                            tmr_r <= tmr_r + 32'h1;
                        end
                    end
                end
                // unused codes fall back to the safe holding state
                default: begin
                    state_r <= MRS_HOLD;
                end
            endcase
        end
    end

    // outputs registered; brake engages whenever the synced request is low, whether or not driving
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            motor_drive <= 1'b0;
            hold_brake  <= 1'b1;
            error_out   <= 1'b0;
            state_out   <= MRS_HOLD;
        end else begin
            // hot gates the drive here too, so it drops on the edge that sees it
            motor_drive <= (state_r == MRS_RUN || state_r == MRS_STALL_TRY) && !hot;
            // the hold follows the synced request alone: a hot stop does not brake
            hold_brake  <= !run_s2_r;
            error_out   <= err_r;
            state_out   <= state_r;
        end
    end
endmodule
`default_nettype wire

//--- design/mrs_consts.svh
// timing and threshold constants for the motor roller fault supervisor
`ifndef MRS_CONSTS_SVH
`define MRS_CONSTS_SVH
`define MRS_CLK_HZ          200000000
`define MRS_TICK_MS         1
`define MRS_TICK_CYC        (`MRS_CLK_HZ / 1000 * `MRS_TICK_MS)
`define MRS_ATTEMPT_MS      1000
`define MRS_STALL_PERIOD_MS 3000
`define MRS_STALL_TRIES     10
`define MRS_SLOW_PERIOD_MS  60000
`define MRS_DEV_LIMIT_MS    10000
`define MRS_LOWSPD_WAIT_MS  60000
`define MRS_DEV_PCT         20
`endif

//--- design/mrs_pkg.sv
// types shared by the motor roller fault supervisor
package mrs_pkg;
    typedef enum logic [2:0] {
        MRS_HOLD,
        MRS_RUN,
        MRS_STALL_TRY,
        MRS_STALL_WAIT,
        MRS_LOW_WAIT,
        MRS_HOT
    } mrs_state_t;
endpackage

//--- design/mrs_tick.sv
// free-running millisecond time base
`timescale 1ns/1ps
`default_nettype none
`include "mrs_consts.svh"
module mrs_tick #(
    parameter int unsigned TICK_CYC = `MRS_TICK_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    output logic      tick_ms
);
    logic [31:0] cnt_r;

    // one-cycle enable every TICK_CYC clocks
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r   <= 32'h0;
            tick_ms <= 1'b0;
        end else if (cnt_r == 32'(TICK_CYC - 1)) begin
            cnt_r   <= 32'h0;
            tick_ms <= 1'b1;
        end else begin
            cnt_r   <= cnt_r + 32'h1;
            tick_ms <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- test/mrs_checker_assertions.sv
// concurrent checks on the fault supervisor ports
`timescale 1ns/1ps
`default_nettype none
module mrs_checker (
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic              run_req_pin,
    input wire logic              motor_hot_in,
    input wire logic              elec_hot_in,
    input wire logic              motor_drive,
    input wire logic              hold_brake,
    input wire logic              error_out,
    input wire logic [2:0]          state_out
);
    import mrs_pkg::*;
    wire logic hot = motor_hot_in | elec_hot_in;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // request gone long enough to pass the two-flop synchroniser
    sequence idle_s; (!run_req_pin && !hot)[*6]; endsequence
    sequence lw_s; state_out == MRS_LOW_WAIT; endsequence
    a_hold_idle: assert property ((!run_req_pin)[*6] |-> hold_brake && !motor_drive)
        else $error("hold missing");
    a_hold_free: assert property (run_req_pin[*5] |-> !hold_brake)
        else $error("hold stuck");
    a_hot_stop: assert property (hot[*3] |-> !motor_drive && error_out && state_out == MRS_HOT)
        else $error("hot not stopped");
    a_cool_leave: assert property (state_out == MRS_HOT && !hot |-> ##[1:3] state_out != MRS_HOT)
        else $error("hot not left");
    a_try_drive: assert property ((state_out == MRS_STALL_TRY && !hot)[*2] |-> motor_drive)
        else $error("try not driven");
    a_wait_off: assert property ((state_out == MRS_STALL_WAIT)[*2] |-> !motor_drive)
        else $error("wait driven");
    a_low_off: assert property (lw_s[*2] |-> !motor_drive && error_out)
        else $error("low wait driven");
    a_low_hold: assert property ($rose(state_out == MRS_LOW_WAIT) |-> lw_s[*8])
        else $error("low wait short");
    a_idle_clear: assert property (idle_s |-> !error_out)
        else $error("error kept idle");
endmodule
`default_nettype wire

//--- test/mrs_roller_model.sv
// roller and load model: measured speed follows the drive
`timescale 1ns/1ps
`default_nettype none
module mrs_roller_model (
    input wire logic        motor_drive,
    input wire logic        blocked,
    input wire logic        drag,
    input wire logic [15:0] speed_set,
    output logic     [15:0] speed_act
);
    // a jammed or unpowered roller reads zero, drag halves the speed
    assign speed_act = (!motor_drive || blocked) ? 16'h0000 : drag ? speed_set >> 1 : speed_set;
endmodule
`default_nettype wire

//--- test/mrs_supervisor_tb.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module mrs_supervisor_tb;
    import mrs_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, run = 1'b0, blk = 1'b0, drag = 1'b0;
    logic mhot = 1'b0, ehot = 1'b0, drv, brk, err;
    logic [15:0] sset = 16'h0100, sact;
    mrs_state_t st;
    int fail_count = 0, checked = 0, cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    // short ms tick keeps the ten-try sequence to under two hundred cycles
    mrs_supervisor #(.TICK_CYC(4), .ATTEMPT_MS(2), .STALL_PERIOD_MS(4), .SLOW_PERIOD_MS(8),
        .DEV_LIMIT_MS(5), .LOWSPD_WAIT_MS(8)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .run_req_pin(run), .blocked_in(blk), .motor_hot_in(mhot), .elec_hot_in(ehot),
        .speed_set(sset), .speed_act(sact), .motor_drive(drv), .hold_brake(brk),
        .error_out(err), .state_out(st));
    mrs_roller_model plant (.motor_drive(drv), .blocked(blk), .drag(drag),
        .speed_set(sset), .speed_act(sact));
    task automatic w(int n); repeat (n) @(negedge clk_sys); endtask
    task automatic chk(string nm, logic e, logic s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %b seen %b", nm, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, far above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic t_hold;
        chk("hold_brake", 1'b1, brk);
        chk("motor_drive", 1'b0, drv);
        run = 1'b1;
        w(8);
        chk("hold_brake", 1'b0, brk);
        $display("hold done");
    endtask
    task automatic t_stall;
        blk = 1'b1;
        w(140);
        chk("error_out", 1'b0, err);
        w(45);
        chk("error_out", 1'b1, err);
        blk = 1'b0;
        w(45);
        chk("error_out", 1'b0, err);
        chk("motor_drive", 1'b1, drv);
        blk = 1'b1;
        w(100);
        chk("error_out", 1'b0, err);
        w(85);
        chk("error_out", 1'b1, err);
        run = 1'b0;
        w(8);
        chk("error_out", 1'b0, err);
        blk = 1'b0;
        $display("stall done");
    endtask
    task automatic t_low;
        sset = 16'h0240;
        run = 1'b1;
        drag = 1'b1;
        w(40);
        chk("error_out", 1'b1, err);
        chk("motor_drive", 1'b0, drv);
        chk("state_out", 1'b1, st == MRS_LOW_WAIT);
        drag = 1'b0;
        w(10);
        chk("motor_drive", 1'b0, drv);
        w(40);
        chk("motor_drive", 1'b1, drv);
        chk("error_out", 1'b0, err);
        $display("low speed done");
    endtask
    task automatic t_hot;
        for (int i = 0; i < 2; i++) begin
            mhot = (i == 0);
            ehot = (i == 1);
            w(5);
            chk("error_out", 1'b1, err);
            chk("motor_drive", 1'b0, drv);
            mhot = 1'b0;
            ehot = 1'b0;
            w(8);
            chk("error_out", 1'b0, err);
            chk("motor_drive", 1'b1, drv);
        end
        $display("hot done");
    endtask
    initial begin
        w(8);
        rstn = 1'b1;
        w(2);
        t_hold();
        t_stall();
        t_low();
        t_hot();
        stop_test();
    end
endmodule
bind mrs_supervisor mrs_checker chk_i (.clk_sys(clk_sys), .rstn(rstn),
    .run_req_pin(run_req_pin), .motor_hot_in(motor_hot_in), .elec_hot_in(elec_hot_in),
    .motor_drive(motor_drive), .hold_brake(hold_brake), .error_out(error_out),
    .state_out(state_out));
`default_nettype wire
